// ### src/lase_gate_pkg.sv
package lase_gate_pkg;
    // =====================================================================
    // timing
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned ENABLE_DLY_S  = 5;
    localparam int unsigned ENABLE_DLY_CYC = CLK_HZ * ENABLE_DLY_S;
    localparam int unsigned SYNC_STAGES   = 2;
    localparam int unsigned SETTLE_CYC    = SYNC_STAGES + 1;

    // =====================================================================
    // synchronised control inputs
    typedef struct packed {
        logic interlock;
        logic gate_req;
        logic restart;
        logic keyswitch;
        logic shutter_sw;
        logic pwm;
    } ctrl_in_s;

    localparam int unsigned CTRL_W = $bits(ctrl_in_s);

    typedef enum logic [1:0] {
        ST_OFF,
        ST_ARMED,
        ST_DELAY,
        ST_ON
    } gate_state_e;
endpackage : lase_gate_pkg

// ### src/input_sync.sv
`timescale 1ns/10ps
module input_sync #(
    parameter int unsigned WIDTH  = 1,
    parameter int unsigned STAGES = 2
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             srst_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    // =====================================================================
    // synchroniser chain; only the last stage is read outside
    logic [WIDTH-1:0] stage_q [STAGES];

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            stage_q[0] <= async_i;
            for (int i = 1; i < STAGES; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign sync_o = stage_q[STAGES-1];
endmodule : input_sync

// ### src/laser_enable_interlock_gate.sv
// What this block does
// R01 - interlock low removes drive, high permits
// R02 - unused interlock is tied high outside
// R03 - key units latch interlock drop until toggle
// R04 - restart toggle starts five second inhibit
// R05 - keyless units re-enable at once on interlock
// R06 - output power follows command duty cycle
// R07 - command pwm 5 kHz nominal, 160 kHz max
// R08 - gate request low removes drive
// R09 - unused gate request is tied high outside
// R10 - key units wait five seconds after gate
// R11 - key units need gate and shutter open
// R12 - restart held disables; release lights ready
// R13 - restart not before 200 ms after power
// R14 - every control input synchronised first
`timescale 1ns/10ps
module laser_enable_interlock_gate
    import lase_gate_pkg::*;
#(
    parameter int unsigned DLY_CYC = ENABLE_DLY_CYC
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic srst_i,
    // unit option, static strap
    input  wire logic has_keyswitch_i,
    // isolated control inputs, active high
    input  wire logic interlock_i,
    input  wire logic gate_req_i,
    input  wire logic restart_i,
    input  wire logic keyswitch_i,
    input  wire logic shutter_sw_i,
    input  wire logic pwm_i,
    // drive and indications
    output logic      drive_pwr_o,
    output logic      rf_drive_o,
    output logic      ready_lamp_o,
    output logic      shutter_lamp_o,
    output logic      lasing_o
);
    // =====================================================================
    // input synchronisation
    ctrl_in_s raw;
    ctrl_in_s syn;
    ctrl_in_s prev_q;
    logic     key_unit_q;

    assign raw = '{interlock:  interlock_i,
                   gate_req:   gate_req_i,
                   restart:    restart_i,
                   keyswitch:  keyswitch_i,
                   shutter_sw: shutter_sw_i,
                   pwm:        pwm_i};

    input_sync #(
        .WIDTH  (CTRL_W),
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .async_i    (raw),
        .sync_o     (syn)
    ); // R14

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            prev_q <= '0;
        end else begin
            prev_q <= syn;
        end
    end

    // strap caught by a clocked process, not by the reset itself
    always_ff @(posedge core_clk_i) begin
        key_unit_q <= has_keyswitch_i;
    end

    // =====================================================================
    // event mask while the synchroniser refills
    logic [3:0] settle_q;
    logic       settled;

    // the chain restarts from zero, so a key already on at release would
    // look like a toggle and skip the power-up restart pulse
    assign settled = (settle_q == 4'(SETTLE_CYC));

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            settle_q <= 4'h0;
        end else if (!settled) begin
            settle_q <= settle_q + 4'h1;
        end
    end

    // =====================================================================
    // restart, keyswitch, gate and interlock events
    logic restart_fall;
    logic key_toggle;
    logic gate_rise;
    logic ilk_fall;

    assign restart_fall = settled & prev_q.restart & ~syn.restart;
    assign key_toggle   = settled & (prev_q.keyswitch ^ syn.keyswitch);
    assign gate_rise    = settled & ~prev_q.gate_req & syn.gate_req;
    assign ilk_fall     = settled & prev_q.interlock & ~syn.interlock;

    // =====================================================================
    // restart latch for keyswitch units
    gate_state_e state_q;
    logic [31:0] dly_q;
    logic        dly_done;

    assign dly_done = (dly_q >= DLY_CYC - 1);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_q <= ST_OFF;
        end else if (!key_unit_q) begin
            state_q <= ST_ON;
        end else if (syn.restart || ilk_fall || !syn.keyswitch) begin
            state_q <= ST_OFF; // R03 R12
        end else begin
            case (state_q)
                ST_OFF: begin
                    if ((restart_fall || key_toggle) && syn.interlock) begin
                        state_q <= ST_DELAY; // R03 R04
                    end
                end
                ST_DELAY: begin
                    if (dly_done) begin
                        state_q <= ST_ON; // R04 R12
                    end
                end
                ST_ON: begin
                    state_q <= ST_ON;
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i || state_q != ST_DELAY) begin
            dly_q <= '0;
        end else if (!dly_done) begin
            dly_q <= dly_q + 32'h1; // R04
        end
    end

    // =====================================================================
    // gate request delay for keyswitch units
    // runs apart from the restart timer, so either one can hold off lasing
    logic [31:0] gdly_q;
    logic        gate_ok;

    assign gate_ok = syn.gate_req && (!key_unit_q || gdly_q >= DLY_CYC - 1);

    always_ff @(posedge core_clk_i) begin
        if (srst_i || !syn.gate_req || gate_rise) begin
            gdly_q <= '0;
        end else if (gdly_q < DLY_CYC - 1) begin
            gdly_q <= gdly_q + 32'h1; // R10
        end
    end

    // =====================================================================
    // enable decision and outputs
    logic ready;
    logic shut_ok;
    logic permit;

    // keyless units: interlock not latched, reassert re-enables at once
    assign ready   = syn.interlock && !syn.restart &&
                     (!key_unit_q || state_q == ST_ON); // R01 R05 R12
    assign shut_ok = gate_ok && (!key_unit_q || syn.shutter_sw); // R08 R11
    assign permit  = ready && shut_ok; // R01 R08


    // =====================================================================
    // registered outputs
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            drive_pwr_o <= 1'b0;
        end else begin
            drive_pwr_o <= permit; // R01 R08
        end
    end

    // duty of the rf gate mirrors the command, so power scales with duty;
    // one cycle per 25 ns gives ample resolution at 160 kHz
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rf_drive_o <= 1'b0;
        end else begin
            rf_drive_o <= permit && syn.pwm; // R06
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ready_lamp_o <= 1'b0;
        end else begin
            ready_lamp_o <= ready; // R12
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            shutter_lamp_o <= 1'b0;
        end else begin
            shutter_lamp_o <= shut_ok; // R11
        end
    end

    // lasing indication tracks the gated command, not the lamps
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            lasing_o <= 1'b0;
        end else begin
            lasing_o <= permit && syn.pwm; // R06
        end
    end
endmodule : laser_enable_interlock_gate

// ### test/lase_gate_sva.sv
`timescale 1ns/10ps
module lase_gate_chk
    import lase_gate_pkg::*;
#(
    parameter int unsigned DLY_CYC = ENABLE_DLY_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // watched inputs
    input wire logic has_keyswitch_i,
    input wire logic interlock_i,
    input wire logic gate_req_i,
    input wire logic restart_i,
    input wire logic keyswitch_i,
    input wire logic shutter_sw_i,
    input wire logic pwm_i,
    // watched outputs
    input wire logic drive_pwr_o,
    input wire logic rf_drive_o,
    input wire logic ready_lamp_o,
    input wire logic shutter_lamp_o,
    input wire logic lasing_o
);
    // =====================================================================
    // timers
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    logic [31:0] ok_q;
    logic [31:0] gt_q;
    // raw pins lead the synchronised ones, so these only ever run ahead
    always_ff @(posedge core_clk_i) begin
        ok_q <= (srst_i | restart_i | ~interlock_i | ~keyswitch_i) ? '0
                : ok_q + 32'h1;
        gt_q <= (srst_i | ~gate_req_i) ? '0 : gt_q + 32'h1;
    end
    // =====================================================================
    // properties
    chk_il_off: assert property (!interlock_i |-> ##3 !drive_pwr_o)
        else $error("drive on after interlock drop");
    chk_gate_off: assert property (!gate_req_i |-> ##3 !drive_pwr_o)
        else $error("drive on after gate drop");
    chk_restart_held: assert property (restart_i |-> ##3
        !drive_pwr_o && !ready_lamp_o) else $error("restart not obeyed");
    chk_keyless_on: assert property ((!has_keyswitch_i && interlock_i
        && gate_req_i && !restart_i)[*3] |=> drive_pwr_o && ready_lamp_o)
        else $error("keyless unit not enabled");
    chk_rf_pwm: assert property (rf_drive_o |-> drive_pwr_o
        && $past(pwm_i, 3)) else $error("rf drive without command");
    chk_shutter_shut: assert property (has_keyswitch_i &&
        !shutter_sw_i |-> ##3 !drive_pwr_o && !shutter_lamp_o)
        else $error("drive with shutter closed");
    chk_key_delay: assert property (has_keyswitch_i &&
        $rose(drive_pwr_o) |-> ok_q >= DLY_CYC) else $error("early start");
    chk_gate_delay: assert property (has_keyswitch_i &&
        $rose(drive_pwr_o) |-> gt_q >= DLY_CYC) else $error("early gate");
    chk_lase_track: assert property (lasing_o ==
        (drive_pwr_o && $past(pwm_i, 3))) else $error("lasing mismatch");
endmodule : lase_gate_chk

bind laser_enable_interlock_gate lase_gate_chk #(
    .DLY_CYC (DLY_CYC)
) u_chk (
    .core_clk_i      (core_clk_i),
    .srst_i          (srst_i),
    .has_keyswitch_i (has_keyswitch_i),
    .interlock_i     (interlock_i),
    .gate_req_i      (gate_req_i),
    .restart_i       (restart_i),
    .keyswitch_i     (keyswitch_i),
    .shutter_sw_i    (shutter_sw_i),
    .pwm_i           (pwm_i),
    .drive_pwr_o     (drive_pwr_o),
    .rf_drive_o      (rf_drive_o),
    .ready_lamp_o    (ready_lamp_o),
    .shutter_lamp_o  (shutter_lamp_o),
    .lasing_o        (lasing_o)
);

// ### test/plc_model.sv
`timescale 1ns/10ps
module plc_model (
    // clock and duty
    input  wire logic       core_clk_i,
    input  wire logic [3:0] duty_i,
    // command
    output logic            pwm_o
);
    // a 256-cycle period keeps the command just under its top rate
    logic [7:0] ph_q  = 8'h00;
    logic       pwm_q = 1'b0;

    always @(negedge core_clk_i) begin
        ph_q  <= ph_q + 8'h01;
        pwm_q <= (ph_q[7:4] < duty_i);
    end

    assign pwm_o = pwm_q;
endmodule : plc_model

// ### test/laser_enable_interlock_gate_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_total++; $display("FAIL %s exp %b got %b", n, e, g); end end
module laser_enable_interlock_gate_tb_top;
    localparam int unsigned DLY = 20;
    logic       clk = 1'b0, srst = 1'b1, key = 1'b0, il = 1'b0;
    logic       gate = 1'b0, rst = 1'b0, ksw = 1'b0, shut = 1'b0;
    logic [3:0] duty = 4'h8;
    logic       pwm, drv, rf, rdy, slamp;
    int         err_total = 0, num_checks = 0;
    // =====================================================================
    // clock, models, helpers
    initial forever #12.5 clk = ~clk;
    plc_model plc (.core_clk_i(clk), .duty_i(duty), .pwm_o(pwm));
    laser_enable_interlock_gate #(.DLY_CYC(DLY)) dut (
        .core_clk_i(clk), .srst_i(srst), .has_keyswitch_i(key),
        .interlock_i(il), .gate_req_i(gate), .restart_i(rst),
        .keyswitch_i(ksw), .shutter_sw_i(shut), .pwm_i(pwm),
        .drive_pwr_o(drv), .rf_drive_o(rf), .ready_lamp_o(rdy),
        .shutter_lamp_o(slamp), .lasing_o());
    function automatic logic exp_drive(input logic [2:0] s);
        return s[2] & s[1] & ~s[0];
    endfunction : exp_drive
    function automatic logic exp_ready(input logic [2:0] s);
        return s[2] & ~s[0];
    endfunction : exp_ready
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    task automatic conclude;
        $display("mismatches %0d checks %0d", err_total, num_checks);
        if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic boot(input logic k);
        srst = 1'b1;
        key = k;
        wt(8);
        srst = 1'b0;
    endtask : boot
    // =====================================================================
    // tests
    initial begin
        logic [2:0] v;
        void'($urandom(32'he60a));
        boot(1'b0);
        il = 1'b1;
        gate = 1'b1;
        wt(2);
        `CHK("sync latency", 1'b0, drv)
        wt(1);
        `CHK("keyless on", 1'b1, drv)
        for (int n = 0; n < 60; n++) begin
            v = 3'($urandom);
            {il, gate, rst} = v;
            duty = 4'($urandom);
            wt(3 + $urandom % 4);
            `CHK("keyless drive", exp_drive(v), drv)
            `CHK("ready lamp", exp_ready(v), rdy)
        end
        boot(1'b1);
        {il, gate, ksw, shut, rst} = 5'h1e;
        wt(DLY + 10);
        `CHK("no restart pulse", 1'b0, drv)
        rst = 1'b1;
        wt(4);
        rst = 1'b0;
        wt(10);
        `CHK("start delay", 1'b0, drv)
        wt(DLY);
        `CHK("key on", 1'b1, drv)
        il = 1'b0;
        wt(4);
        il = 1'b1;
        wt(DLY + 10);
        `CHK("latched off", 1'b0, drv)
        ksw = 1'b0;
        wt(4);
        ksw = 1'b1;
        wt(DLY + 10);
        `CHK("key toggle", 1'b1, drv)
        shut = 1'b0;
        wt(3);
        `CHK("shutter shut", 1'b0, drv)
        `CHK("shutter lamp", 1'b0, slamp)
        shut = 1'b1;
        gate = 1'b0;
        wt(4);
        gate = 1'b1;
        wt(DLY / 2);
        `CHK("gate delay", 1'b0, drv)
        wt(DLY);
        `CHK("gate on", 1'b1, drv)
        conclude();
    end
    // the whole run needs well under 1000 cycles
    initial begin
        wt(2000);
        err_total++;
        conclude();
    end
endmodule : laser_enable_interlock_gate_tb_top
